// ### design/trigger_router.v
// Overview of operation
// - Clearing the last task stops the controller and drops every route.
// - Shared clock line source may only drive the master timebase.
// - Backplane star trigger accepted only in slot 3 or higher.
// - Backplane 10 MHz clock routes only to the master timebase.
// - Local oscillator exports only to shared clock line, not on card-slot.
// - Resync clock is 10 Hz, 50 percent, to lines 0..6; realign on pulse.
// - Filtered frame-received pulse, one bit wide, is routable.
// - Transceiver fault source is active low, high when healthy.
// - One start trigger begins sampling for every task of the interface.
// - Unrouted start trigger fires when communication begins.
// - Start trigger may drive any general line 0..6.
// - First-generation card rejects advanced sources with an error.
// - Connect reports signed status: zero ok, negative error, positive warning.
// - Routed start trigger fires on first rising edge of its source.
// - Unrouted master timebase falls back to the local oscillator.
`include "router_defines.vh"

module trigger_router #(
  parameter RESYNC_HALF = `RESYNC_HALF,
  parameter DIV_W       = 24,
  parameter TASK_W      = 4
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Card facts
  input  wire        card_gen2,
  input  wire [1:0]  form_factor,
  input  wire [4:0]  slot_number,
  // Trigger lines 0..6 and shared clock line 7
  input  wire [7:0]  trig_line_in,
  output reg  [7:0]  trig_line_out,
  output reg  [7:0]  trig_line_oe_n,
  // Backplane and local sources
  input  wire        backplane_star_in,
  input  wire        backplane_clk10_in,
  input  wire        osc_local_in,
  input  wire        frame_received_in,
  input  wire        transceiver_fault_n,
  // Controller side
  output reg         controller_run,
  output reg  [1:0]  acceptance_filter_mode,
  output reg         sampling_start,
  output reg         sampling_started,
  // Timebase
  output reg         master_timebase,
  output reg  [1:0]  timebase_source,
  output reg         resync_align,
  // Interrupt
  output reg         irq
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready;
  wire wr_cmd  = access & pwrite & (paddr == `ADDR_CMD);
  wire wr_task = access & pwrite & (paddr == `ADDR_TASK);
  wire wr_mask = access & pwrite & (paddr == `ADDR_IRQ_MASK);
  wire wr_cfg  = access & pwrite & (paddr == `ADDR_CFG);
  wire rd_irq  = access & ~pwrite & (paddr == `ADDR_IRQ_STAT);

  reg [3:0]          dst_src_reg [0:`DST_COUNT-1];
  reg [31:0]         status_reg;
  reg [TASK_W-1:0]   task_count_reg;
  reg [`IRQ_W-1:0]   irq_stat_reg;
  reg [`IRQ_W-1:0]   irq_mask_reg;
  reg                start_level_reg;
  reg                comm_begin_reg;
  reg [31:0]         rd_next;
  reg                mapped;

  always @* begin
    mapped  = 1'b1;
    rd_next = 32'h00000000;
    case (paddr)
      `ADDR_CMD:      rd_next = 32'h00000000;
      `ADDR_STATUS:   rd_next = status_reg;
      `ADDR_TASK:     rd_next = {{(30-TASK_W){1'b0}}, controller_run,
                                 sampling_started, task_count_reg};
      `ADDR_ROUTE_LO: rd_next = {dst_src_reg[7], dst_src_reg[6],
                                 dst_src_reg[5], dst_src_reg[4],
                                 dst_src_reg[3], dst_src_reg[2],
                                 dst_src_reg[1], dst_src_reg[0]};
      `ADDR_ROUTE_HI: rd_next = {20'h00000, dst_src_reg[10],
                                 dst_src_reg[9], dst_src_reg[8]};
      `ADDR_IRQ_STAT: rd_next = {{(32-`IRQ_W){1'b0}}, irq_stat_reg};
      `ADDR_IRQ_MASK: rd_next = {{(32-`IRQ_W){1'b0}}, irq_mask_reg};
      `ADDR_CFG:      rd_next = {30'h00000000, acceptance_filter_mode};
      default:        mapped  = 1'b0;
    endcase
  end

  // Zero wait state: answer is ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= rd_next;
      end
    end
  end

  // ****************************************
  // Source values
  // ****************************************
  wire       resync_level;
  wire [15:0] src_vals = {1'b0, start_level_reg,
                          transceiver_fault_n,
                          frame_received_in,
                          resync_level, osc_local_in,
                          backplane_clk10_in, backplane_star_in,
                          trig_line_in};

  // ****************************************
  // Connection check
  // ****************************************
  wire [3:0] cmd_src  = pwdata[`CMD_SRC_LSB+3:`CMD_SRC_LSB];
  wire [3:0] cmd_dst  = pwdata[`CMD_DST_LSB+3:`CMD_DST_LSB];
  wire       cmd_disc = pwdata[`CMD_DISC_BIT];
  wire       dst_line = (cmd_dst <= `DST_LINE6);
  reg        ok_pair;
  reg        need_gen2;
  reg        ok_form;
  reg        ok_slot;
  reg [31:0] chk_status;

  always @* begin
    ok_pair   = 1'b0;
    need_gen2 = 1'b0;
    ok_form   = 1'b1;
    ok_slot   = 1'b1;
    case (cmd_src)
      `SRC_SHCLK: begin
        ok_pair   = (cmd_dst == `DST_MTB);
        need_gen2 = 1'b1;
      end
      `SRC_STAR: begin
        ok_pair   = (cmd_dst == `DST_START);
        need_gen2 = 1'b1;
        ok_form   = (form_factor == `FF_BACKPLANE);
        ok_slot   = (slot_number >= `STAR_MIN_SLOT);
      end
      `SRC_CLK10: begin
        ok_pair   = (cmd_dst == `DST_MTB);
        need_gen2 = 1'b1;
        ok_form   = (form_factor == `FF_BACKPLANE);
      end
      `SRC_OSC: begin
        ok_pair   = (cmd_dst == `DST_SHCLK);
        need_gen2 = 1'b1;
        ok_form   = (form_factor != `FF_CARDSLOT);
      end
      `SRC_RESYNC: begin
        ok_pair   = dst_line;
      end
      `SRC_FRAME, `SRC_FAULT: begin
        ok_pair   = dst_line;
        need_gen2 = 1'b1;
      end
      `SRC_START: begin
        ok_pair   = dst_line;
      end
      `SRC_NONE: begin
        ok_pair   = 1'b0;
      end
      default: begin
        // General lines feed the resync and start destinations
        ok_pair   = (cmd_dst == `DST_RESYNC) || (cmd_dst == `DST_START);
      end
    endcase
    if (!ok_pair) begin
      chk_status = `STAT_ERR_PAIR;
    end else if (need_gen2 && !card_gen2) begin
      chk_status = `STAT_ERR_GEN1;
    end else if (!ok_form) begin
      chk_status = `STAT_ERR_FORM;
    end else if (!ok_slot) begin
      chk_status = `STAT_ERR_SLOT;
    end else if (cmd_disc) begin
      chk_status = (dst_src_reg[cmd_dst] == cmd_src) ? `STAT_OK : `STAT_WARN_NOP;
    end else begin
      chk_status = (dst_src_reg[cmd_dst] == `SRC_NONE ||
                    dst_src_reg[cmd_dst] == cmd_src) ? `STAT_OK : `STAT_WARN_REPL;
    end
  end

  wire chk_error = chk_status[31];

  // ****************************************
  // Tasks and routing table
  // ****************************************
  wire task_start = wr_task & pwdata[`TASK_START_BIT];
  wire task_clear = wr_task & pwdata[`TASK_CLEAR_BIT];
  wire last_clear = task_clear & ~task_start &
                    (task_count_reg == {{(TASK_W-1){1'b0}}, 1'b1});
  integer i;
  integer j;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `DST_COUNT; i = i + 1) begin
        dst_src_reg[i] <= `SRC_NONE;
      end
      status_reg             <= `STAT_OK;
      task_count_reg         <= {TASK_W{1'b0}};
      controller_run         <= 1'b0;
      comm_begin_reg         <= 1'b0;
      acceptance_filter_mode <= 2'h0;
    end else begin
      comm_begin_reg <= 1'b0;
      if (wr_cfg) begin
        acceptance_filter_mode <= pwdata[1:0];
      end
      if (last_clear) begin
        task_count_reg <= {TASK_W{1'b0}};
        controller_run <= 1'b0;
        for (i = 0; i < `DST_COUNT; i = i + 1) begin
          dst_src_reg[i] <= `SRC_NONE;
        end
      end else begin
        if (task_start && !task_clear && !(&task_count_reg)) begin
          task_count_reg <= task_count_reg + 1'b1;
          controller_run <= 1'b1;
          comm_begin_reg <= (task_count_reg == {TASK_W{1'b0}});
        end else if (task_clear && !task_start &&
                     task_count_reg != {TASK_W{1'b0}}) begin
          task_count_reg <= task_count_reg - 1'b1;
        end
        if (wr_cmd) begin
          status_reg <= chk_status;
          if (!chk_error) begin
            if (!cmd_disc) begin
              dst_src_reg[cmd_dst] <= cmd_src;
            end else if (dst_src_reg[cmd_dst] == cmd_src) begin
              dst_src_reg[cmd_dst] <= `SRC_NONE;
            end
          end
        end
      end
    end
  end

  // ****************************************
  // Line drive and timebase selection
  // ****************************************
  wire [3:0] mtb_src = dst_src_reg[`DST_MTB];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_line_out   <= 8'h00;
      trig_line_oe_n  <= 8'hFF;
      master_timebase <= 1'b0;
      timebase_source <= `TB_LOCAL;
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        trig_line_out[j]  <= src_vals[dst_src_reg[j]];
        trig_line_oe_n[j] <= (dst_src_reg[j] == `SRC_NONE);
      end
      case (mtb_src)
        `SRC_SHCLK: begin
          master_timebase <= trig_line_in[7];
          timebase_source <= `TB_SHCLK;
        end
        `SRC_CLK10: begin
          master_timebase <= backplane_clk10_in;
          timebase_source <= `TB_CLK10;
        end
        default: begin
          master_timebase <= osc_local_in;
          timebase_source <= `TB_LOCAL;
        end
      endcase
    end
  end

  // ****************************************
  // Resync clock and realignment
  // ****************************************
  wire [3:0] rsy_src  = dst_src_reg[`DST_RESYNC];
  wire       rsy_rise;

  rise_detect u_rsy_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     ((rsy_src != `SRC_NONE) & src_vals[rsy_src]),
    .rise    (rsy_rise)
  );

  // Realigning our own generator keeps re-exported pulses in phase
  resync_clock_gen #(
    .HALF_COUNT (RESYNC_HALF),
    .WIDTH      (DIV_W)
  ) u_resync_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .align   (rsy_rise),
    .level   (resync_level)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_align <= 1'b0;
    end else begin
      resync_align <= rsy_rise;
    end
  end

  // ****************************************
  // Start trigger
  // ****************************************
  wire [3:0] st_src = dst_src_reg[`DST_START];
  wire       st_rise;

  rise_detect u_start_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     ((st_src != `SRC_NONE) & src_vals[st_src]),
    .rise    (st_rise)
  );

  // One trigger per interface, shared by all tasks on it
  wire st_fire = controller_run & ~sampling_started &
                 ((st_src == `SRC_NONE) ? comm_begin_reg
                                        : st_rise);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampling_start   <= 1'b0;
      sampling_started <= 1'b0;
      start_level_reg  <= 1'b0;
    end else begin
      sampling_start <= st_fire;
      if (last_clear) begin
        sampling_started <= 1'b0;
        start_level_reg  <= 1'b0;
      end else if (st_fire) begin
        sampling_started <= 1'b1;
        start_level_reg  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire fault_fall;
  wire frame_rise;

  rise_detect u_fault_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (~transceiver_fault_n),
    .rise    (fault_fall)
  );

  rise_detect u_frame_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .sig     (frame_received_in),
    .rise    (frame_rise)
  );

  wire [`IRQ_W-1:0] irq_set = {frame_rise, fault_fall, st_fire,
                               wr_cmd & chk_error};
  // New events win over the read that clears
  wire [`IRQ_W-1:0] irq_stat_next = (rd_irq ? {`IRQ_W{1'b0}} : irq_stat_reg)
                                    | irq_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= {`IRQ_W{1'b0}};
      irq_mask_reg <= {`IRQ_W{1'b0}};
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_mask) begin
        irq_mask_reg <= pwdata[`IRQ_W-1:0];
      end
      irq <= |(irq_stat_next & (wr_mask ? pwdata[`IRQ_W-1:0] : irq_mask_reg));
    end
  end

endmodule // trigger_router

// ### inc/router_defines.vh
`ifndef ROUTER_DEFINES_VH
`define ROUTER_DEFINES_VH

// ****************************************
// Register byte addresses
// ****************************************
`define ADDR_CMD        8'h00
`define ADDR_STATUS     8'h04
`define ADDR_TASK       8'h08
`define ADDR_ROUTE_LO   8'h0C
`define ADDR_ROUTE_HI   8'h10
`define ADDR_IRQ_STAT   8'h14
`define ADDR_IRQ_MASK   8'h18
`define ADDR_CFG        8'h1C

// ****************************************
// Field positions
// ****************************************
`define CMD_SRC_LSB     0
`define CMD_DST_LSB     4
`define CMD_DISC_BIT    8
`define TASK_START_BIT  0
`define TASK_CLEAR_BIT  1
`define IRQ_ERR_BIT     0
`define IRQ_START_BIT   1
`define IRQ_FAULT_BIT   2
`define IRQ_FRAME_BIT   3
`define IRQ_W           4

// ****************************************
// Source terminals
// ****************************************
`define SRC_LINE6       4'h6
`define SRC_SHCLK       4'h7
`define SRC_STAR        4'h8
`define SRC_CLK10       4'h9
`define SRC_OSC         4'hA
`define SRC_RESYNC      4'hB
`define SRC_FRAME       4'hC
`define SRC_FAULT       4'hD
`define SRC_START       4'hE
`define SRC_NONE        4'hF

// ****************************************
// Destination terminals
// ****************************************
`define DST_LINE6       4'h6
`define DST_SHCLK       4'h7
`define DST_MTB         4'h8
`define DST_RESYNC      4'h9
`define DST_START       4'hA
`define DST_COUNT       11

// ****************************************
// Status codes, signed 32 bit
// ****************************************
`define STAT_OK         32'h00000000
`define STAT_WARN_REPL  32'h00000001
`define STAT_WARN_NOP   32'h00000002
`define STAT_ERR_PAIR   32'hFFFFFFFF
`define STAT_ERR_GEN1   32'hFFFFFFFE
`define STAT_ERR_FORM   32'hFFFFFFFD
`define STAT_ERR_SLOT   32'hFFFFFFFC

// ****************************************
// Card facts and timing
// ****************************************
`define FF_DESKTOP      2'h0
`define FF_BACKPLANE    2'h1
`define FF_CARDSLOT     2'h2
`define STAR_MIN_SLOT   5'h03
`define TB_LOCAL        2'h0
`define TB_SHCLK        2'h1
`define TB_CLK10        2'h2
`define CLK_HZ          250000000
`define RESYNC_HZ       10
`define RESYNC_HALF     (`CLK_HZ / (2 * `RESYNC_HZ))

`endif

// ### design/rise_detect.v
module rise_detect (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Signal in, edge out
  input  wire sig,
  output wire rise
);

  reg prev_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig;
    end
  end

  assign rise = sig & ~prev_reg;

endmodule // rise_detect

// ### design/resync_clock_gen.v
module resync_clock_gen #(
  parameter HALF_COUNT = 12500000,
  parameter WIDTH      = 24
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Realign to phase zero
  input  wire align,
  // Square wave, 50 percent duty
  output reg  level
);

  reg [WIDTH-1:0] count_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {WIDTH{1'b0}};
      level     <= 1'b0;
    end else if (align) begin
      count_reg <= {WIDTH{1'b0}};
      level     <= 1'b0;
    end else if (count_reg == HALF_COUNT[WIDTH-1:0] - 1'b1) begin
      count_reg <= {WIDTH{1'b0}};
      level     <= ~level;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule // resync_clock_gen

// ### verification/router_chk_sva.sv
`include "router_defines.vh"

module router_chk (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Bus and card facts
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire        card_gen2,
  input wire [1:0]  form_factor,
  // Routed outputs and local oscillator input
  input wire [7:0]  trig_line_oe_n,
  input wire        osc_local_in,
  input wire        controller_run,
  input wire        sampling_start,
  input wire        sampling_started,
  input wire        master_timebase,
  input wire [1:0]  timebase_source
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence fire_pulse;
    sampling_start ##1 !sampling_start;
  endsequence
  AST_PREADY_NEXT: assert property (apb_setup |=> pready)
    else $error("pready missing after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_FIRE_ONCE: assert property (sampling_start |-> fire_pulse ##0 sampling_started)
    else $error("start pulse malformed");
  AST_FIRE_RUNS: assert property (sampling_start |-> controller_run)
    else $error("start fired while stopped");
  AST_NO_REFIRE: assert property ($past(sampling_started) && sampling_started |-> !sampling_start)
    else $error("start fired twice");
  AST_STARTED_BY_FIRE: assert property ($rose(sampling_started) |-> sampling_start)
    else $error("started without pulse");
  // Route drop may land one cycle after the run flag
  AST_CLEAR_DROPS: assert property ($fell(controller_run) |->
    !sampling_started ##[0:1] trig_line_oe_n == 8'hFF)
    else $error("routes kept after last clear");
  AST_TB_LOCAL: assert property ($past(presetn) && timebase_source == `TB_LOCAL &&
    $past(timebase_source) == `TB_LOCAL |-> master_timebase == $past(osc_local_in))
    else $error("timebase not local oscillator");
  AST_SHCLK_LEGAL: assert property ($changed(timebase_source) &&
    timebase_source == `TB_SHCLK |-> card_gen2)
    else $error("shared clock timebase on first gen");
  AST_CLK10_LEGAL: assert property ($changed(timebase_source) && timebase_source == `TB_CLK10
    |-> card_gen2 && form_factor == `FF_BACKPLANE)
    else $error("backplane clock timebase illegal");
  AST_EXPORT_LEGAL: assert property ($fell(trig_line_oe_n[7]) |->
    card_gen2 && form_factor != `FF_CARDSLOT)
    else $error("oscillator export illegal");
endmodule // router_chk

bind trigger_router router_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .card_gen2(card_gen2),
  .form_factor(form_factor), .trig_line_oe_n(trig_line_oe_n), .osc_local_in(osc_local_in),
  .controller_run(controller_run), .sampling_start(sampling_start),
  .sampling_started(sampling_started), .master_timebase(master_timebase),
  .timebase_source(timebase_source));

// ### verification/line_partner.sv
`include "router_defines.vh"

module line_partner (
  // Clock and card fact
  input  wire logic       pclk,
  input  wire logic [1:0] form_factor,
  // Partner drive of lines 0..6
  input  wire logic [6:0] drv_en,
  input  wire logic [6:0] drv_val,
  // Card side of the lines
  input  wire logic [7:0] trig_line_out,
  input  wire logic [7:0] trig_line_oe_n,
  output logic      [7:0] trig_line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Shared line levels
  // ****************************************
  logic       tb_clk = 1'h0;
  logic [6:0] idle   = 7'h55;
  // Off-grid start keeps timebase edges away from pclk edges
  initial #0.7 forever #((form_factor == `FF_CARDSLOT) ? 50 : 25) tb_clk = ~tb_clk;
  // Released lines have no pull: show a changing pattern
  always @(posedge pclk) idle <= ~idle;
  always @* begin
    for (int k = 0; k < 7; k++) begin
      trig_line_in[k] = !trig_line_oe_n[k] ? trig_line_out[k] : drv_en[k] ? drv_val[k] : idle[k];
    end
    trig_line_in[7] = !trig_line_oe_n[7] ? trig_line_out[7] : tb_clk;
  end
endmodule // line_partner

// ### verification/can_trigger_timebase_router_tb.sv
`include "router_defines.vh"

module can_trigger_timebase_router_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Bench
  // ****************************************
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, trig_line_in, trig_line_out, trig_line_oe_n;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, card_gen2 = 1'h1, osc = 1'h0, clk10 = 1'h0;
  logic [1:0]  form_factor = `FF_BACKPLANE, acceptance_filter_mode, timebase_source;
  logic [4:0]  slot_number = 5'h05;
  logic [6:0]  drv_en = 7'h00, drv_val = 7'h00;
  logic        frame = 1'h0, fault_n = 1'h1, controller_run, sampling_start, sampling_started;
  logic        master_timebase, resync_align, irq, fired;
  int          num_errors = 0, cmp_count = 0, cycles = 0, hi;

  always #2 pclk = ~pclk;
  initial #1.3 forever #25 osc = ~osc;
  initial #1.7 forever #50 clk10 = ~clk10;

  trigger_router #(.RESYNC_HALF(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_gen2(card_gen2), .form_factor(form_factor),
    .slot_number(slot_number), .trig_line_in(trig_line_in), .trig_line_out(trig_line_out),
    .trig_line_oe_n(trig_line_oe_n), .backplane_star_in(1'h0), .backplane_clk10_in(clk10),
    .osc_local_in(osc), .frame_received_in(frame), .transceiver_fault_n(fault_n),
    .controller_run(controller_run), .acceptance_filter_mode(acceptance_filter_mode),
    .sampling_start(sampling_start), .sampling_started(sampling_started),
    .master_timebase(master_timebase), .timebase_source(timebase_source),
    .resync_align(resync_align), .irq(irq));
  line_partner u_partner (.pclk(pclk), .form_factor(form_factor), .drv_en(drv_en),
    .drv_val(drv_val), .trig_line_out(trig_line_out), .trig_line_oe_n(trig_line_oe_n),
    .trig_line_in(trig_line_in));

  task conclude;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle edge first, so psel never gets two assignments in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata; err = pslverr;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task cmd(input logic [3:0] s, input logic [3:0] d, input logic disc, input logic [31:0] exp);
    apb(1'h1, `ADDR_CMD, {23'h0, disc, d, s});
    apb(1'h0, `ADDR_STATUS, 32'h0);
    chk(rd, exp);
  endtask

  task t_regs;
    apb(1'h0, `ADDR_ROUTE_LO, 32'h0); chk(rd, 32'hFFFFFFFF);
    apb(1'h0, `ADDR_ROUTE_HI, 32'h0); chk(rd, 32'h00000FFF);
    apb(1'h0, `ADDR_IRQ_MASK, 32'h0); chk(rd, 32'h0);
    apb(1'h0, 8'h20, 32'h0); chk({rd[30:0], err}, 32'h1);
    apb(1'h1, `ADDR_CFG, 32'h3);
    @(posedge pclk);
    chk({30'h0, acceptance_filter_mode}, 32'h3);
    chk({30'h0, timebase_source}, {30'h0, `TB_LOCAL});
    $display("t_regs done");
  endtask
  task t_routes;
    cmd(`SRC_RESYNC, 4'h2, 1'h0, `STAT_OK);
    cmd(`SRC_CLK10, `DST_MTB, 1'h0, `STAT_OK);
    chk({30'h0, timebase_source}, {30'h0, `TB_CLK10});
    cmd(`SRC_SHCLK, `DST_MTB, 1'h0, `STAT_WARN_REPL);
    chk({30'h0, timebase_source}, {30'h0, `TB_SHCLK});
    cmd(`SRC_OSC, `DST_SHCLK, 1'h0, `STAT_OK);
    cmd(`SRC_START, 4'h3, 1'h0, `STAT_OK);
    cmd(`SRC_FRAME, 4'h4, 1'h0, `STAT_OK);
    cmd(`SRC_FAULT, 4'h5, 1'h0, `STAT_OK);
    cmd(`SRC_RESYNC, 4'h0, 1'h1, `STAT_WARN_NOP);
    chk({24'h0, trig_line_oe_n}, 32'h43);
    apb(1'h0, `ADDR_ROUTE_LO, 32'h0); chk(rd, 32'hAFDCEBFF);
    $display("t_routes done");
  endtask
  task t_refuse;
    cmd(`SRC_SHCLK, 4'h2, 1'h0, `STAT_ERR_PAIR);
    cmd(`SRC_CLK10, 4'h3, 1'h0, `STAT_ERR_PAIR);
    cmd(`SRC_OSC, 4'h2, 1'h0, `STAT_ERR_PAIR);
    cmd(4'h0, 4'h3, 1'h0, `STAT_ERR_PAIR);
    card_gen2 <= 1'h0;
    cmd(`SRC_FRAME, 4'h4, 1'h0, `STAT_ERR_GEN1);
    cmd(`SRC_SHCLK, `DST_MTB, 1'h0, `STAT_ERR_GEN1);
    cmd(`SRC_RESYNC, 4'h2, 1'h0, `STAT_OK);
    card_gen2 <= 1'h1; form_factor <= `FF_CARDSLOT;
    cmd(`SRC_OSC, `DST_SHCLK, 1'h0, `STAT_ERR_FORM);
    form_factor <= `FF_DESKTOP;
    cmd(`SRC_CLK10, `DST_MTB, 1'h0, `STAT_ERR_FORM);
    cmd(`SRC_STAR, `DST_START, 1'h0, `STAT_ERR_FORM);
    form_factor <= `FF_BACKPLANE; slot_number <= 5'h02;
    cmd(`SRC_STAR, `DST_START, 1'h0, `STAT_ERR_SLOT);
    slot_number <= 5'h03;
    cmd(`SRC_STAR, `DST_START, 1'h0, `STAT_OK);
    apb(1'h0, `ADDR_ROUTE_LO, 32'h0); chk(rd, 32'hAFDCEBFF);
    cmd(`SRC_STAR, `DST_START, 1'h1, `STAT_OK);
    $display("t_refuse done");
  endtask
  task t_lines;
    frame <= 1'h1;
    repeat (3) @(posedge pclk);
    chk({31'h0, trig_line_out[4]}, 32'h1);
    frame <= 1'h0; fault_n <= 1'h0;
    repeat (3) @(posedge pclk);
    chk({31'h0, trig_line_out[5]}, 32'h0);
    fault_n <= 1'h1;
    repeat (3) @(posedge pclk);
    chk({31'h0, trig_line_out[5]}, 32'h1);
    hi = 0;
    repeat (32) begin
      @(posedge pclk);
      hi += trig_line_out[2];
    end
    chk(hi, 32'd16);
    $display("t_lines done");
  endtask
  task t_start_default;
    apb(1'h0, `ADDR_IRQ_STAT, 32'h0);
    apb(1'h1, `ADDR_IRQ_MASK, 32'h2);
    apb(1'h1, `ADDR_TASK, 32'h1);
    for (int i = 1; i < 5; i++) begin
      @(posedge pclk);
      chk({31'h0, sampling_start}, {31'h0, i == 2});
    end
    chk({31'h0, irq}, 32'h1);
    apb(1'h0, `ADDR_IRQ_STAT, 32'h0); chk(rd & 32'h2, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `ADDR_TASK, 32'h1);
    apb(1'h0, `ADDR_TASK, 32'h0); chk(rd, 32'h32);
    apb(1'h1, `ADDR_TASK, 32'h2);
    apb(1'h0, `ADDR_TASK, 32'h0); chk(rd, 32'h31);
    apb(1'h1, `ADDR_TASK, 32'h2);
    apb(1'h0, `ADDR_TASK, 32'h0); chk(rd, 32'h0);
    apb(1'h0, `ADDR_ROUTE_LO, 32'h0); chk(rd, 32'hFFFFFFFF);
    chk({24'h0, trig_line_oe_n}, 32'hFF);
    chk({30'h0, timebase_source}, {30'h0, `TB_LOCAL});
    $display("t_start_default done");
  endtask
  task t_start_routed;
    drv_en <= 7'h02; drv_val <= 7'h00;
    cmd(4'h1, `DST_START, 1'h0, `STAT_OK);
    cmd(4'h1, `DST_RESYNC, 1'h0, `STAT_OK);
    apb(1'h1, `ADDR_TASK, 32'h1);
    fired = 1'h0;
    hi = 0;
    repeat (8) @(posedge pclk) fired |= sampling_start;
    chk({31'h0, fired}, 32'h0);
    drv_val <= 7'h02;
    repeat (6) @(posedge pclk) begin
      fired |= sampling_start;
      hi += resync_align;
    end
    chk({31'h0, fired}, 32'h1);
    chk(hi, 32'd1);
    apb(1'h1, `ADDR_TASK, 32'h2);
    drv_en <= 7'h00;
    $display("t_start_routed done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_routes;
    t_refuse;
    t_lines;
    t_start_default;
    t_start_routed;
    conclude;
  end
endmodule // can_trigger_timebase_router_tb
